// [hdl/vac_attribute_controller.sv]
`timescale 1ns/100ps
//
// Contract
// - Read at either input-status address presets toggle to index state.
// - Every write to the attribute port flips the toggle, unless a status read comes in the same cycle.
// - Reads of the index or data address leave the toggle alone.
// - Index reads back at the write port, indexed data one address higher.
// - Five index bits pick attribute register 0 through 14 hex.
// - Index bit 5 clear: palette off display unless wide pixel addressing is selected, CPU may reach entries.
// - Sixteen six-bit palette entries translate four-bit codes to colour.
// - Mode bit 0 picks text attributes or graphics colour.
// - Mode bit 1 picks colour or monochrome text attributes.
// - Line graphics codes copy eighth dot into ninth; else background.
// - Mode bit 3 makes attribute top bit intensity or blink.
// - Blink counter divides vertical retrace by 32, 16 on 16 off.
// - Graphics blink inverts colour bit 3 on alternate phases.
// - Text cursor blinks 8 retraces on, 8 off.
// - Top panning forces pan to zero from line compare until vsync.
// - Mode bit 6 packs two nibbles into one 8-bit pixel.
// - Mode bit 7 picks video bits 5-4 source; 7-6 from padding.
// - Border colour shows outside active display unless wide pixel addressing is selected.
// - Clear plane enable bits force colour plane bits to zero.
// - Test select routes two colour bits to status outputs.
module vac_attribute_controller (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic pixel_address_width_select,
    input wire logic dot_en,
    input wire logic display_active,
    input wire logic [3:0] plane_data,
    input wire logic [7:0] char_code,
    input wire logic [7:0] char_attr,
    input wire logic glyph_dot,
    input wire logic ninth_column,
    input wire logic cursor_active,
    input wire logic vertical_retrace_input,
    input wire logic line_compare_match,
    input wire logic vsync_start,
    output logic [7:0] video_out,
    output logic video_valid,
    output logic [3:0] pan_out,
    output logic [1:0] video_test_status,
    output logic index_data_toggle,
    output logic display_palette_enable
);
    import vac_pkg::*;

    vac_state_type st_reg;
    vac_state_type st_next;

    // decoded helpers
    logic pal_sel;
    logic pal_cpu_ok;
    logic status_rd;
    logic [4:0] idx;
    logic [7:0] data_rd;
    logic [3:0] fg;
    logic [3:0] bg;
    logic [3:0] code;
    logic dot;
    logic line_gfx_char;
    logic [5:0] pal_out;
    logic [7:0] pixel;
    logic pal_on_display;

    assign idx = st_reg.index[4:0];
    assign pal_sel = (idx <= VAC_IDX_PAL_LAST);
    // in the wide pixel-address mode the enable bit has no effect
    assign pal_on_display = st_reg.index[VAC_INDEX_PAL_ENB] | pixel_address_width_select;
    assign pal_cpu_ok = ~pal_on_display | pixel_address_width_select;
    assign status_rd = io_rd & ((io_addr == VAC_ADDR_STATUS_MONO) | (io_addr == VAC_ADDR_STATUS_COLOR));
    assign line_gfx_char = (char_code >= VAC_LGC_FIRST) && (char_code <= VAC_LGC_LAST);

    // read mux of the indexed register, unused indexes read zero
    always_comb begin
        data_rd = 8'h00;
        case (idx)
            VAC_IDX_MODE: data_rd = st_reg.mode;
            VAC_IDX_BORDER: data_rd = st_reg.border;
            VAC_IDX_PLANE: data_rd = {2'b00, st_reg.plane};
            VAC_IDX_PAN: data_rd = {4'h0, st_reg.pan};
            VAC_IDX_PAD: data_rd = {4'h0, st_reg.pad};
            default: begin
                if (pal_sel && pal_cpu_ok) begin
                    data_rd = {2'b00, st_reg.pal[idx[3:0]]};
                end
            end
        endcase
    end

    // text and graphics attribute decode ahead of the palette
    always_comb begin
        fg = char_attr[3:0];
        bg = char_attr[7:4];
        dot = glyph_dot;
        if (ninth_column) begin
            // glyph_dot carries the eighth dot during the ninth column
            dot = st_reg.mode[VAC_MODE_LINE_GFX] & line_gfx_char & glyph_dot;
        end
        if (st_reg.mode[VAC_MODE_MONO]) begin
            // monochrome: intensity plus on/off, reverse video shows a lit background
            fg = (char_attr[2:0] == 3'b000) ? 4'h0 : {char_attr[3], 3'b111};
            bg = (char_attr[6:4] == 3'b111) ? 4'h7 : 4'h0;
        end
        if (st_reg.mode[VAC_MODE_BLINK]) begin
            bg[3] = 1'b0;
            if (char_attr[7] && st_reg.blink[VAC_CHAR_PHASE_BIT]) begin
                dot = 1'b0;
            end
        end
        if (cursor_active && !st_reg.blink[VAC_CURSOR_PHASE_BIT]) begin
            dot = 1'b1;
        end
        if (st_reg.mode[VAC_MODE_GRAPHICS]) begin
            code = plane_data;
            if (st_reg.mode[VAC_MODE_BLINK] && st_reg.blink[VAC_CHAR_PHASE_BIT]) begin
                code[3] = ~code[3];
            end
        end else begin
            code = dot ? fg : bg;
        end
        code = code & st_reg.plane[3:0];
        pal_out = st_reg.pal[code];
        pixel = {st_reg.pad[3:2], st_reg.mode[VAC_MODE_HIGH_SEL] ? st_reg.pad[1:0] : pal_out[5:4],
            pal_out[3:0]};
    end

    // next state: host port, blink, panning and pixel pipeline
    always_comb begin
        st_next = st_reg;
        st_next.vr_prev = vertical_retrace_input;
        // host writes alternate between index and data
        if (io_wr && io_addr == VAC_ADDR_INDEX) begin
            st_next.toggle = ~st_reg.toggle;
            if (!st_reg.toggle) begin
                st_next.index = io_wdata[5:0];
            end else begin
                case (idx)
                    VAC_IDX_MODE: st_next.mode = io_wdata & VAC_MODE_WMASK;
                    VAC_IDX_BORDER: st_next.border = io_wdata;
                    VAC_IDX_PLANE: st_next.plane = io_wdata[5:0];
                    VAC_IDX_PAN: st_next.pan = io_wdata[3:0];
                    VAC_IDX_PAD: st_next.pad = io_wdata[3:0];
                    default: begin
                        if (pal_sel && pal_cpu_ok) begin
                            st_next.pal[idx[3:0]] = io_wdata[5:0];
                        end
                    end
                endcase
            end
        end
        // status read presets the toggle, and beats a same-cycle write
        if (status_rd) begin
            st_next.toggle = 1'b0;
        end
        // read data, registered; reads of the port do not move the toggle
        if (io_rd) begin
            if (io_addr == VAC_ADDR_INDEX) begin
                st_next.rdata = {2'b00, st_reg.index};
            end else if (io_addr == VAC_ADDR_DATA) begin
                st_next.rdata = data_rd;
            end else begin
                st_next.rdata = 8'h00;
            end
        end
        // blink counter steps on each retrace rising edge
        if (vertical_retrace_input && !st_reg.vr_prev) begin
            st_next.blink = st_reg.blink + 1'b1;
        end
        // split screen: lower part unpanned until the next frame
        if (!st_reg.mode[VAC_MODE_TOP_PANNING_ENABLE] || vsync_start) begin
            st_next.pan_zero = 1'b0;
        end else if (line_compare_match) begin
            st_next.pan_zero = 1'b1;
        end
        st_next.pan_out = st_next.pan_zero ? 4'h0 : st_next.pan;
        // pixel stage
        st_next.video_valid = 1'b0;
        if (dot_en) begin
            if (!display_active) begin
                st_next.video = pixel_address_width_select ? 8'h00 : st_reg.border;
                st_next.video_valid = 1'b1;
                st_next.half = 1'b0;
            end else if (!pal_on_display) begin
                // palette is owned by the host, show the border colour
                st_next.video = st_reg.border;
                st_next.video_valid = 1'b1;
                st_next.half = 1'b0;
            end else if (st_reg.mode[VAC_MODE_EIGHT_BIT]) begin
                // first nibble is the high half, pixel emitted on the second
                st_next.half = ~st_reg.half;
                if (!st_reg.half) begin
                    st_next.first = pixel[3:0];
                end else begin
                    st_next.video = {st_reg.first, pixel[3:0]};
                    st_next.video_valid = 1'b1;
                end
            end else begin
                st_next.video = pixel;
                st_next.video_valid = 1'b1;
                st_next.half = 1'b0;
            end
        end
        // diagnostic bits follow the displayed colour
        case (st_reg.plane[5:4])
            2'b00: st_next.test = {st_reg.video[2], st_reg.video[0]};
            2'b01: st_next.test = {st_reg.video[5], st_reg.video[4]};
            2'b10: st_next.test = {st_reg.video[3], st_reg.video[1]};
            default: st_next.test = {st_reg.video[7], st_reg.video[6]};
        endcase
    end

    // all state in one register; palette resets too for a clean start
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg.toggle <= 1'b0;
            st_reg.index <= VAC_INDEX_RST;
            st_reg.pal <= {16{VAC_PAL_RST}};
            st_reg.mode <= VAC_MODE_RST;
            st_reg.border <= VAC_BORDER_RST;
            st_reg.plane <= VAC_PLANE_RST;
            st_reg.pan <= VAC_PAN_RST;
            st_reg.pad <= VAC_PAD_RST;
            st_reg.rdata <= 8'h00;
            st_reg.video <= 8'h00;
            st_reg.video_valid <= 1'b0;
            st_reg.half <= 1'b0;
            st_reg.first <= 4'h0;
            st_reg.blink <= '0;
            st_reg.vr_prev <= 1'b0;
            st_reg.pan_zero <= 1'b0;
            st_reg.pan_out <= 4'h0;
            st_reg.test <= 2'b00;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign io_rdata = st_reg.rdata;
    assign video_out = st_reg.video;
    assign video_valid = st_reg.video_valid;
    assign pan_out = st_reg.pan_out;
    assign video_test_status = st_reg.test;
    assign index_data_toggle = st_reg.toggle;
    assign display_palette_enable = st_reg.index[VAC_INDEX_PAL_ENB];

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    chk_status_preset: assert property (status_rd |=> !index_data_toggle)
        else $error("status read did not preset toggle");
    chk_write_flips: assert property (io_wr && io_addr == VAC_ADDR_INDEX && !status_rd
        |=> index_data_toggle != $past(index_data_toggle))
        else $error("port write did not flip toggle");
    chk_read_keeps: assert property (io_rd && !io_wr && !status_rd |=> $stable(index_data_toggle))
        else $error("port read moved toggle");
    chk_index_readback: assert property (io_rd && io_addr == VAC_ADDR_INDEX
        |=> io_rdata == {2'b00, $past(st_reg.index)})
        else $error("index readback wrong");
    chk_index_load: assert property (io_wr && io_addr == VAC_ADDR_INDEX && !index_data_toggle
        |=> st_reg.index == $past(io_wdata[5:0]))
        else $error("index not loaded");
    chk_blink_step: assert property (vertical_retrace_input && !st_reg.vr_prev
        |=> st_reg.blink == $past(st_reg.blink) + 5'd1)
        else $error("blink counter missed retrace");
    chk_pan_forced: assert property (st_reg.pan_zero |-> pan_out == 4'h0)
        else $error("pan not forced to zero");
    chk_mode_reserved: assert property (st_reg.mode[4] == 1'b0)
        else $error("reserved mode bit set");
    chk_high_bits: assert property (video_valid && !$past(st_reg.mode[VAC_MODE_EIGHT_BIT])
        && $past(display_active) && $past(pal_on_display) |-> video_out[7:6] == $past(st_reg.pad[3:2]))
        else $error("high video bits not from padding");
    chk_border_out: assert property (dot_en && !display_active && !pixel_address_width_select
        |=> video_out == $past(st_reg.border))
        else $error("border colour not shown");

    cov_index_then_data: cover property (io_wr && io_addr == VAC_ADDR_INDEX && !index_data_toggle
        ##[1:8] io_wr && io_addr == VAC_ADDR_INDEX);
    cov_eight_bit_pixel: cover property (video_valid && st_reg.mode[VAC_MODE_EIGHT_BIT]);
    cov_split_pan: cover property (line_compare_match && st_reg.mode[VAC_MODE_TOP_PANNING_ENABLE] ##1 st_reg.pan_zero);
endmodule // vac_attribute_controller

// [hdl/vac_pkg.sv]
package vac_pkg;
    // i/o addresses of the host port
    localparam logic [15:0] VAC_ADDR_STATUS_MONO = 16'h03ba;
    localparam logic [15:0] VAC_ADDR_STATUS_COLOR = 16'h03da;
    localparam logic [15:0] VAC_ADDR_INDEX = 16'h03c0;
    localparam logic [15:0] VAC_ADDR_DATA = 16'h03c1;
    // indexed register numbers
    localparam logic [4:0] VAC_IDX_PAL_LAST = 5'h0f;
    localparam logic [4:0] VAC_IDX_MODE = 5'h10;
    localparam logic [4:0] VAC_IDX_BORDER = 5'h11;
    localparam logic [4:0] VAC_IDX_PLANE = 5'h12;
    localparam logic [4:0] VAC_IDX_PAN = 5'h13;
    localparam logic [4:0] VAC_IDX_PAD = 5'h14;
    // field positions of the mode control and index registers
    localparam int VAC_MODE_GRAPHICS = 0;
    localparam int VAC_MODE_MONO = 1;
    localparam int VAC_MODE_LINE_GFX = 2;
    localparam int VAC_MODE_BLINK = 3;
    localparam int VAC_MODE_TOP_PANNING_ENABLE = 5;
    localparam int VAC_MODE_EIGHT_BIT = 6;
    localparam int VAC_MODE_HIGH_SEL = 7;
    localparam int VAC_INDEX_PAL_ENB = 5;
    // writable bit masks, reserved bits stay zero
    localparam logic [7:0] VAC_MODE_WMASK = 8'hef;
    // reset values
    localparam logic [7:0] VAC_MODE_RST = 8'h00;
    localparam logic [7:0] VAC_BORDER_RST = 8'h00;
    localparam logic [5:0] VAC_PLANE_RST = 6'h00;
    localparam logic [3:0] VAC_PAN_RST = 4'h0;
    localparam logic [3:0] VAC_PAD_RST = 4'h0;
    localparam logic [5:0] VAC_INDEX_RST = 6'h00;
    localparam logic [5:0] VAC_PAL_RST = 6'h00;
    // line graphics character code range
    localparam logic [7:0] VAC_LGC_FIRST = 8'hc0;
    localparam logic [7:0] VAC_LGC_LAST = 8'hdf;
    // blink counter: 32 retraces per character period, cursor bit halves it
    localparam int VAC_BLINK_W = 5;
    localparam int VAC_CHAR_PHASE_BIT = 4;
    localparam int VAC_CURSOR_PHASE_BIT = 3;

    typedef struct packed {
        logic toggle;
        logic [5:0] index;
        logic [15:0][5:0] pal;
        logic [7:0] mode;
        logic [7:0] border;
        logic [5:0] plane;
        logic [3:0] pan;
        logic [3:0] pad;
        logic [7:0] rdata;
        logic [7:0] video;
        logic video_valid;
        logic half;
        logic [3:0] first;
        logic [VAC_BLINK_W-1:0] blink;
        logic vr_prev;
        logic pan_zero;
        logic [3:0] pan_out;
        logic [1:0] test;
    } vac_state_type;
endpackage

// [testbench/vac_host_model.sv]
`timescale 1ns/100ps
// host cpu on the i/o port: one strobe a transfer, an idle edge between
module vac_host_model (
    input wire logic mclk,
    output logic io_wr,
    output logic io_rd,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    import vac_pkg::*;
    // idle bus at time zero
    initial begin
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
    end
    // released lines show the inverse so stale values cannot pass as live
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge mclk);
        io_wr <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
        @(posedge mclk);
    endtask
    // read data is registered, taken one edge after the strobe edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge mclk);
        io_rd <= 1'b0;
        io_addr <= ~a;
        @(posedge mclk);
        d = io_rdata;
    endtask
    // every pair starts from a status read, so a lost write cannot skew it
    task automatic put(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] s;
        rd(VAC_ADDR_STATUS_COLOR, s);
        wr(VAC_ADDR_INDEX, idx);
        wr(VAC_ADDR_INDEX, d);
    endtask
    task automatic get(input logic [7:0] idx, output logic [7:0] d);
        logic [7:0] s;
        rd(VAC_ADDR_STATUS_COLOR, s);
        wr(VAC_ADDR_INDEX, idx);
        rd(VAC_ADDR_DATA, d);
    endtask
endmodule // vac_host_model

// [testbench/vac_attribute_controller_bench.sv]
`timescale 1ns/100ps
`define CHECK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end
module vac_attribute_controller_bench;
    import vac_pkg::*;
    logic mclk, rstn, io_wr, io_rd, pws, dot_en, act, vr, lcm, vs, video_valid, tgl, pal_en;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, video_out;
    logic [3:0] pd, pan_out;
    logic [1:0] vts;
    logic gd, nc, cur;
    logic [7:0] cc, attr;
    int miscompares = 0;
    int checks_done = 0;
    vac_host_model host_u (.mclk(mclk), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    // text inputs driven by the text scenario
    vac_attribute_controller dut_u (.mclk(mclk), .rstn(rstn), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .pixel_address_width_select(pws), .dot_en(dot_en), .display_active(act),
        .plane_data(pd), .char_code(cc), .char_attr(attr), .glyph_dot(gd),
        .ninth_column(nc), .cursor_active(cur), .vertical_retrace_input(vr),
        .line_compare_match(lcm), .vsync_start(vs), .video_out(video_out),
        .video_valid(video_valid), .pan_out(pan_out), .video_test_status(vts),
        .index_data_toggle(tgl), .display_palette_enable(pal_en));
    // clock, 40 ns period
    always #20 mclk = ~mclk;
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one dot in, colour judged one cycle later
    task automatic dot(input logic [3:0] p, input logic a, input logic [7:0] exp);
        pd <= p;
        act <= a;
        dot_en <= 1'b1;
        @(posedge mclk);
        dot_en <= 1'b0;
        #1;
        `CHECK("video_valid", 1'b1, video_valid)
        `CHECK("video_out", exp, video_out)
        @(posedge mclk);
    endtask
    task automatic retrace(input int n);
        repeat (n) begin
            vr <= 1'b1;
            @(posedge mclk);
            vr <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // pan is checked mid-cycle, away from the edge that updates it
    task automatic pan_pulse(input logic top, input logic [3:0] exp);
        if (top) vs <= 1'b1; else lcm <= 1'b1;
        @(posedge mclk);
        vs <= 1'b0;
        lcm <= 1'b0;
        @(negedge mclk);
        `CHECK("pan_out", exp, pan_out)
        @(posedge mclk);
    endtask
    task automatic t_toggle();
        logic [7:0] d;
        `CHECK("toggle", 1'b0, tgl)
        host_u.wr(VAC_ADDR_INDEX, 8'h30);
        `CHECK("toggle", 1'b1, tgl)
        host_u.rd(VAC_ADDR_INDEX, d);
        `CHECK("index", 8'h30, d)
        host_u.rd(VAC_ADDR_DATA, d);
        `CHECK("mode", 8'h00, d)
        `CHECK("toggle", 1'b1, tgl)
        host_u.wr(VAC_ADDR_INDEX, 8'h41);
        `CHECK("toggle", 1'b0, tgl)
        host_u.rd(VAC_ADDR_DATA, d);
        `CHECK("mode", 8'h41, d)
        host_u.wr(VAC_ADDR_INDEX, 8'h31);
        host_u.rd(VAC_ADDR_STATUS_MONO, d);
        `CHECK("toggle", 1'b0, tgl)
        $display("test toggle done");
    endtask
    // all-ones written to each control register, index 15 hex and palette entry 5; reserved bits and index 15 hex come back zero
    task automatic t_regs();
        logic [7:0] idx[7] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h05};
        logic [7:0] exp[7] = '{8'hef, 8'hff, 8'h3f, 8'h0f, 8'h0f, 8'h00, 8'h3f};
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            host_u.put(idx[i], 8'hff);
            host_u.get(idx[i], d);
            `CHECK("register", exp[i], d)
        end
        host_u.put(8'h25, 8'h00);
        host_u.get(8'h05, d);
        `CHECK("palette locked", 8'h3f, d)
        pws <= 1'b1;
        host_u.put(8'h25, 8'h11);
        host_u.get(8'h05, d);
        `CHECK("palette wide", 8'h11, d)
        pws <= 1'b0;
        host_u.rd(VAC_ADDR_STATUS_COLOR, d);
        host_u.wr(VAC_ADDR_INDEX, 8'hff);
        host_u.rd(VAC_ADDR_INDEX, d);
        `CHECK("index", 8'h3f, d)
        $display("test registers done");
    endtask
    task automatic t_video();
        host_u.put(8'h05, 8'h2a);
        host_u.put(8'h01, 8'h15);
        host_u.put(8'h0d, 8'h07);
        host_u.put(8'h34, 8'h0d);
        host_u.put(8'h31, 8'h5c);
        host_u.put(8'h30, 8'h01);
        host_u.put(8'h32, 8'h0f);
        `CHECK("palette enable", 1'b1, pal_en)
        dot(4'h5, 1'b1, 8'hea);
        host_u.put(8'h32, 8'h01);
        dot(4'h5, 1'b1, 8'hd5);
        host_u.put(8'h30, 8'h81);
        host_u.put(8'h32, 8'h1f);
        dot(4'h5, 1'b1, 8'hda);
        @(negedge mclk);
        `CHECK("test status", 2'b01, vts)
        @(posedge mclk);
        dot(4'h5, 1'b0, 8'h5c);
        host_u.put(8'h12, 8'h0f);
        `CHECK("palette enable", 1'b0, pal_en)
        dot(4'h5, 1'b1, 8'h5c);
        host_u.put(8'h30, 8'h09);
        host_u.put(8'h32, 8'h0f);
        retrace(15);
        dot(4'h5, 1'b1, 8'hea);
        retrace(1);
        dot(4'h5, 1'b1, 8'hc7);
        $display("test video done");
    endtask
    // text decode; blink counter stands at 16 here, so cursor phase is on
    task automatic t_text();
        host_u.put(8'h07, 8'h2a);
        host_u.put(8'h30, 8'h00);
        {cc, attr, gd, nc, cur} <= {8'h41, 8'h15, 1'b1, 1'b0, 1'b0};
        dot(4'h0, 1'b1, 8'hea);
        gd <= 1'b0;
        dot(4'h0, 1'b1, 8'hd5);
        host_u.put(8'h30, 8'h04);
        {cc, gd, nc} <= {8'hc4, 1'b1, 1'b1};
        dot(4'h0, 1'b1, 8'hea);
        cc <= 8'h41;
        dot(4'h0, 1'b1, 8'hd5);
        host_u.put(8'h30, 8'h02);
        {attr, nc} <= {8'h01, 1'b0};
        dot(4'h0, 1'b1, 8'hea);
        host_u.put(8'h30, 8'h08);
        attr <= 8'h95;
        dot(4'h0, 1'b1, 8'hd5);
        host_u.put(8'h30, 8'h00);
        dot(4'h0, 1'b1, 8'hea);
        {gd, cur, attr} <= {1'b0, 1'b1, 8'h15};
        dot(4'h0, 1'b1, 8'hea);
        retrace(8);
        dot(4'h0, 1'b1, 8'hd5);
        cur <= 1'b0;
        $display("test text done");
    endtask
    task automatic t_pan();
        host_u.put(8'h33, 8'h05);
        host_u.put(8'h30, 8'h21);
        `CHECK("pan_out", 4'h5, pan_out)
        pan_pulse(1'b0, 4'h0);
        pan_pulse(1'b1, 4'h5);
        host_u.put(8'h30, 8'h01);
        pan_pulse(1'b0, 4'h5);
        $display("test panning done");
    endtask
    // reset for 12 cycles, then the tests in order
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        {pws, dot_en, act, vr, lcm, vs} = 6'h00;
        pd = 4'h0;
        {cc, attr, gd, nc, cur} = 19'h00000;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        t_toggle();
        t_regs();
        t_video();
        t_text();
        t_pan();
        end_of_test();
    end
    // watchdog, well beyond the run of about 360 cycles
    initial begin
        repeat (6000) @(posedge mclk);
        miscompares++;
        end_of_test();
    end
endmodule // vac_attribute_controller_bench
